// ==== design/pdc_power_down_ctrl.sv ====
`timescale 1ns/1ps
`include "pdc_cfg.svh"
// Overview of operation
// - Power-down low disables all input and output buffers.
// - In power-down inputs read low and all pull-ups are off.
// - Reconfiguration request keeps working regardless of power-down.
// - Global set/reset held asserted through the whole power-down.
// - Entering: inputs off and set/reset first, outputs off ~10 ns later.
// - Leaving: inputs on, set/reset released, outputs on ~10 ns later.
// - Configuration kept, flip-flop data lost, logic sees inputs low.
// - Power-down before or during configuration restarts configuration.
// - Init status invalid if power-down came before configuration done.
// - Boundary scan unusable in power-down; pin not in scan chain.
// - Single mode pin: 1 slave serial, 0 master serial.
// - Two mode pins: 11 slave, 10 master, 0X express.
// - Mode pins sampled before configuration, ignored after it.
// - Weak pull-ups on mode pins during configuration.
// - Serial configuration drives high pin high and low pin low.
// - Config clock output in master serial, input otherwise.
// - Init status pin is open-drain while configuring.
// - Test select high keeps test controller in reset.
// - Global set/reset sets or clears flops per their polarity.
// - Output-disable floats outputs unless external test runs.
module pdc_power_down_ctrl #(
	parameter bit TWO_PIN = 1'b1,
	parameter int GAP_CYC = `PDC_GAP_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_power_down_n,
	input wire logic i_program_n,
	input wire logic i_mode_select_hi,
	input wire logic i_mode_select_lo,
	input wire logic i_test_mode_select,
	input wire logic i_extest,
	input wire logic i_config_done,
	input wire logic i_init_low_req,
	input wire logic [`PDC_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_input_enable,
	output logic o_output_enable,
	output logic o_pullup_enable,
	output logic o_mode_pullup_enable,
	output logic o_global_set_reset,
	output logic o_global_output_disable,
	output logic o_tap_reset,
	output logic o_bscan_usable,
	output logic o_config_restart,
	output logic [1:0] o_config_mode,
	output logic o_config_clock_oe,
	output pdc_pkg::pdc_pin_t o_high_during_config,
	output pdc_pkg::pdc_pin_t o_low_during_config,
	output pdc_pkg::pdc_pin_t o_init
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [`PDC_NPIN-1:0] pin_raw;
	logic [`PDC_NPIN-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
	assign pin_raw = {i_test_mode_select, i_mode_select_lo, i_mode_select_hi,
		i_program_n, i_power_down_n};

	genvar g;
	generate
		for (g = 0; g < `PDC_NPIN; g++) begin : g_sync
			// Pins idle high, so reset to the pulled-up level
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					s1_ff[g] <= 1'b1;
					s2_ff[g] <= 1'b1;
					s3_ff[g] <= 1'b1;
					pin_ff[g] <= 1'b1;
				end else begin
					s1_ff[g] <= pin_raw[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					if (s2_ff[g] == s3_ff[g]) begin
						pin_ff[g] <= s3_ff[g];
					end
				end
			end
		end
	endgenerate

	logic pd_req;
	logic prog_req;
	assign pd_req = !pin_ff[`PDC_PIN_PD];
	assign prog_req = !pin_ff[`PDC_PIN_PROG];

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	function automatic pdc_pkg::pdc_mode_t decode_mode(input logic hi, input logic lo);
		if (!TWO_PIN) begin
			decode_mode = lo ? pdc_pkg::PDC_SLAVE_SERIAL : pdc_pkg::PDC_MASTER_SERIAL;
		end else if (!hi) begin
			decode_mode = pdc_pkg::PDC_EXPRESS;
		end else begin
			decode_mode = lo ? pdc_pkg::PDC_SLAVE_SERIAL : pdc_pkg::PDC_MASTER_SERIAL;
		end
	endfunction : decode_mode

	// ----------------------------------------
	// Power-down sequencer
	// ----------------------------------------
	pdc_pkg::pdc_state_t state_ff, nxt_state;
	logic [`PDC_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic cnt_done;
	assign cnt_done = (cnt_ff == `PDC_CNT_W'(GAP_CYC - 1));

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = '0;
		case (state_ff)
			pdc_pkg::PDC_RUN: begin
				if (pd_req) begin
					nxt_state = pdc_pkg::PDC_PD_ENTER;
				end
			end
			pdc_pkg::PDC_PD_ENTER: begin
				// Outputs wait out the gap even if the pin already returned
				nxt_cnt = cnt_ff + `PDC_CNT_W'(1);
				if (cnt_done) begin
					nxt_state = pdc_pkg::PDC_PD;
				end
			end
			pdc_pkg::PDC_PD: begin
				if (!pd_req) begin
					nxt_state = pdc_pkg::PDC_PD_LEAVE;
				end
			end
			default: begin
				nxt_cnt = cnt_ff + `PDC_CNT_W'(1);
				if (cnt_done) begin
					nxt_state = pdc_pkg::PDC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff <= pdc_pkg::PDC_RUN;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	logic in_pd_next;
	logic out_off_next;
	assign in_pd_next = (nxt_state == pdc_pkg::PDC_PD_ENTER) || (nxt_state == pdc_pkg::PDC_PD);
	assign out_off_next = (nxt_state == pdc_pkg::PDC_PD) || (nxt_state == pdc_pkg::PDC_PD_LEAVE);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic sw_gsr_ff, sw_gts_ff;
	logic start_pulse;
	assign start_pulse = i_wr && (i_addr == `PDC_REG_CTRL) && i_wdata[`PDC_CTRL_START];

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sw_gsr_ff <= 1'b0;
			sw_gts_ff <= 1'b0;
		end else if (i_wr && (i_addr == `PDC_REG_CTRL)) begin
			sw_gsr_ff <= i_wdata[`PDC_CTRL_GSR];
			sw_gts_ff <= i_wdata[`PDC_CTRL_GTS];
		end
	end

	// ----------------------------------------
	// Configuration tracking
	// ----------------------------------------
	logic configured_ff, busy_ff;
	pdc_pkg::pdc_mode_t mode_ff;
	logic leaving_pd;
	assign leaving_pd = (state_ff == pdc_pkg::PDC_PD_LEAVE) && cnt_done;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			configured_ff <= 1'b0;
			busy_ff <= 1'b0;
			mode_ff <= pdc_pkg::PDC_SLAVE_SERIAL;
			o_config_restart <= 1'b0;
		end else begin
			o_config_restart <= 1'b0;
			if (prog_req) begin
				// Reconfiguration request acts even in power-down
				configured_ff <= 1'b0;
				busy_ff <= 1'b0;
			end else if (in_pd_next && !configured_ff) begin
				busy_ff <= 1'b0;
			end else if (leaving_pd && !configured_ff) begin
				o_config_restart <= 1'b1;
				busy_ff <= 1'b1;
				mode_ff <= decode_mode(pin_ff[`PDC_PIN_MHI], pin_ff[`PDC_PIN_MLO]);
			end else if (busy_ff && i_config_done) begin
				busy_ff <= 1'b0;
				configured_ff <= 1'b1;
			end else if (start_pulse && !busy_ff && !configured_ff &&
				state_ff == pdc_pkg::PDC_RUN) begin
				busy_ff <= 1'b1;
				mode_ff <= decode_mode(pin_ff[`PDC_PIN_MHI], pin_ff[`PDC_PIN_MLO]);
			end
		end
	end

	logic serial_cfg_next;
	assign serial_cfg_next = busy_ff && !in_pd_next && (mode_ff != pdc_pkg::PDC_EXPRESS);

	// ----------------------------------------
	// Buffer and global net outputs
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_input_enable <= 1'b1;
			o_output_enable <= 1'b1;
			o_pullup_enable <= 1'b1;
			o_global_set_reset <= 1'b0;
			o_global_output_disable <= 1'b0;
			o_tap_reset <= 1'b1;
			o_bscan_usable <= 1'b1;
		end else begin
			o_input_enable <= !in_pd_next;
			o_pullup_enable <= !in_pd_next;
			o_output_enable <= !out_off_next;
			// Flop polarity is applied at each flop, this net only says when
			o_global_set_reset <= in_pd_next || sw_gsr_ff;
			o_global_output_disable <= (out_off_next || sw_gts_ff) && !i_extest;
			o_tap_reset <= in_pd_next || pin_ff[`PDC_PIN_TMS];
			o_bscan_usable <= !in_pd_next;
		end
	end

	// ----------------------------------------
	// Configuration pins
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_mode_pullup_enable <= 1'b0;
			o_config_mode <= 2'h0;
			o_config_clock_oe <= 1'b0;
			o_high_during_config <= '0;
			o_low_during_config <= '0;
			o_init <= '0;
		end else begin
			o_mode_pullup_enable <= !configured_ff && !in_pd_next;
			o_config_mode <= mode_ff;
			o_config_clock_oe <= busy_ff && !in_pd_next &&
				(mode_ff == pdc_pkg::PDC_MASTER_SERIAL);
			o_high_during_config <= '{out: 1'b1, oe: serial_cfg_next};
			o_low_during_config <= '{out: 1'b0, oe: serial_cfg_next};
			// Open-drain: only ever pulls low, and says nothing in power-down
			o_init <= '{out: 1'b0, oe: busy_ff && i_init_low_req && !in_pd_next};
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= '0;
			if (i_rd && (i_addr == `PDC_REG_CTRL)) begin
				o_rdata[`PDC_CTRL_GSR] <= sw_gsr_ff;
				o_rdata[`PDC_CTRL_GTS] <= sw_gts_ff;
			end else if (i_rd && (i_addr == `PDC_REG_STATUS)) begin
				o_rdata[`PDC_ST_STATE_LO +: 2] <= state_ff;
				o_rdata[`PDC_ST_MODE_LO +: 2] <= mode_ff;
				o_rdata[`PDC_ST_CONFIGURED] <= configured_ff;
				o_rdata[`PDC_ST_BUSY] <= busy_ff;
				o_rdata[`PDC_ST_PD] <= pd_req;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	a_inputs_off_pd: assert property (
		$rose(pd_req) && state_ff == pdc_pkg::PDC_RUN |=> !o_input_enable && o_output_enable)
		else $error("inputs not disabled ahead of outputs");
	a_pullups_off: assert property (!o_input_enable |-> !o_pullup_enable)
		else $error("pull-ups on while inputs disabled");
	a_gsr_held: assert property (!o_input_enable |-> o_global_set_reset)
		else $error("set/reset released during power-down");
	a_out_gap: assert property (
		$fell(o_input_enable) |-> o_output_enable [*2] ##1 !o_output_enable)
		else $error("outputs not disabled after the gap");
	a_out_on_gap: assert property (
		$rose(o_input_enable) |-> !o_output_enable [*2] ##1 o_output_enable)
		else $error("outputs not enabled after the gap");
	a_restart_cfg: assert property (
		$rose(o_input_enable) && !configured_ff && !prog_req |=> ##1 o_config_restart)
		else $error("configuration not restarted");
	a_init_quiet: assert property (!o_input_enable |-> !o_init.oe)
		else $error("init pin driven in power-down");
	a_tap_reset: assert property (pin_ff[`PDC_PIN_TMS] |=> o_tap_reset)
		else $error("test controller not held in reset");
	a_config_clock_dir: assert property (
		o_config_clock_oe |-> o_config_mode == pdc_pkg::PDC_MASTER_SERIAL)
		else $error("config clock driven outside master serial");
	a_gts_extest: assert property (i_extest |=> !o_global_output_disable)
		else $error("outputs floated during external test");

	c_pd_cycle: cover property ($fell(o_input_enable) ##[1:100] $rose(o_output_enable));
	c_restart: cover property (o_config_restart);
	c_master_cfg: cover property (o_config_clock_oe);

endmodule : pdc_power_down_ctrl

// ==== design/pdc_cfg.svh ====
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
// Timing
`define PDC_CLK_PERIOD_NS 8
`define PDC_BUF_GAP_NS 10
`define PDC_GAP_CYC ((`PDC_BUF_GAP_NS + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS)
`define PDC_CNT_W 4
// Register map
`define PDC_ADDR_W 4
`define PDC_REG_CTRL 4'h0
`define PDC_REG_STATUS 4'h4
// Control fields
`define PDC_CTRL_GSR 0
`define PDC_CTRL_GTS 1
`define PDC_CTRL_START 2
// Status fields
`define PDC_ST_STATE_LO 0
`define PDC_ST_MODE_LO 2
`define PDC_ST_CONFIGURED 4
`define PDC_ST_BUSY 5
`define PDC_ST_PD 6
// Pin synchroniser slots
`define PDC_NPIN 5
`define PDC_PIN_PD 0
`define PDC_PIN_PROG 1
`define PDC_PIN_MHI 2
`define PDC_PIN_MLO 3
`define PDC_PIN_TMS 4
`endif

// ==== design/pdc_pkg.sv ====
package pdc_pkg;
	typedef enum logic [1:0] {
		PDC_RUN = 2'b00,
		PDC_PD_ENTER = 2'b01,
		PDC_PD = 2'b10,
		PDC_PD_LEAVE = 2'b11
	} pdc_state_t;
	typedef enum logic [1:0] {
		PDC_SLAVE_SERIAL = 2'b00,
		PDC_MASTER_SERIAL = 2'b01,
		PDC_EXPRESS = 2'b10
	} pdc_mode_t;
	typedef struct packed {
		logic out;
		logic oe;
	} pdc_pin_t;
endpackage : pdc_pkg

// ==== verif/pdc_board_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Board logic on the power-down and mode pins
// ----------------------------------------
module pdc_board_model (
	input wire logic i_clk,
	input wire logic i_pd_req,
	input wire logic [1:0] i_mode,
	output logic o_power_down_n,
	output logic o_mode_select_hi,
	output logic o_mode_select_lo,
	output logic o_test_mode_select,
	output logic o_settled
);
	int cnt;
	initial begin
		o_power_down_n = 1'b1;
		cnt = 7;
	end
	// Low pulse kept at least 8 cycles, 64 ns, so no pulse is too short
	// Plain always: the initial block above also sets these
	always @(posedge i_clk) begin
		if (cnt < 7) cnt <= cnt + 1;
		if (o_power_down_n && i_pd_req && cnt >= 7) begin
			o_power_down_n <= 1'b0;
			cnt <= 0;
		end else if (!o_power_down_n && !i_pd_req && cnt >= 7) begin
			o_power_down_n <= 1'b1;
			cnt <= 0;
		end
	end
	// Use only 7 cycles, 56 ns, after release; configuring only with the pin high
	assign o_settled = o_power_down_n && cnt >= 7;
	assign o_mode_select_hi = i_mode[1];
	assign o_mode_select_lo = i_mode[0];
	// Test select held high keeps scan idle while configuring
	assign o_test_mode_select = 1'b1;
endmodule : pdc_board_model

// ==== verif/tb_pdc_power_down_ctrl.sv ====
`timescale 1ns/1ps
module tb_pdc_power_down_ctrl;
	typedef struct {logic [1:0] pins; logic [1:0] mode; logic config_clock; logic high_during_config;} pdc_row_t;
	pdc_row_t rows [4] = '{'{2'h3, 2'h0, 1'b0, 1'b1}, '{2'h2, 2'h1, 1'b1, 1'b1},
		'{2'h1, 2'h2, 1'b0, 1'b0}, '{2'h0, 2'h2, 1'b0, 1'b0}};
	logic i_clk = 0, i_rstn = 0, pd_req = 0, prog_n = 1, done = 0, wr = 0, rd = 0;
	logic extest = 0, init_req = 1, mpu;
	logic [1:0] mode = 2'h3;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, rdv;
	logic pd_n, mhi, mlo, tms, settled, in_en, out_en, pu, global_set_reset, global_output_disable, tap, bsu, rst, config_clock_oe;
	logic [1:0] cmode;
	pdc_pkg::pdc_pin_t high_during_config, low_during_config, init_pin;
	int n_mismatch = 0, n_tests = 0;
	initial forever #4 i_clk = ~i_clk;
	pdc_board_model board (.i_clk(i_clk), .i_pd_req(pd_req), .i_mode(mode),
		.o_power_down_n(pd_n), .o_mode_select_hi(mhi), .o_mode_select_lo(mlo),
		.o_test_mode_select(tms), .o_settled(settled));
	pdc_power_down_ctrl dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_power_down_n(pd_n),
		.i_program_n(prog_n), .i_mode_select_hi(mhi), .i_mode_select_lo(mlo),
		.i_test_mode_select(tms), .i_extest(extest), .i_config_done(done),
		.i_init_low_req(init_req), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_input_enable(in_en), .o_output_enable(out_en),
		.o_pullup_enable(pu), .o_mode_pullup_enable(mpu), .o_global_set_reset(global_set_reset),
		.o_global_output_disable(global_output_disable), .o_tap_reset(tap), .o_bscan_usable(bsu),
		.o_config_restart(rst), .o_config_mode(cmode), .o_config_clock_oe(config_clock_oe),
		.o_high_during_config(high_during_config), .o_low_during_config(low_during_config), .o_init(init_pin));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task give_verdict;
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : give_verdict
	task chk(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	// Bounded wait on the input enable; a hang ends the run
	task wait_in(input logic v);
		for (int i = 0; i < 30 && in_en !== v; i++) @(negedge i_clk);
		if (in_en !== v) begin
			chk(0, "input enable timeout");
			give_verdict();
		end
	endtask : wait_in
	task rd_reg(input logic [3:0] a);
		@(posedge i_clk) rd <= 1'b1;
		addr <= a;
		@(posedge i_clk) rd <= 1'b0;
		@(negedge i_clk) rdv = rdata;
	endtask : rd_reg
	task pd_cycle(input logic exp_rst);
		@(posedge i_clk) pd_req <= 1'b1;
		wait_in(1'b0);
		chk(global_set_reset === 1'b1 && pu === 1'b0 && out_en === 1'b1 && bsu === 1'b0, "enter");
		chk(mpu === 1'b0, "mode pull-ups in power-down");
		@(negedge i_clk) chk(out_en === 1'b1, "gap short");
		@(negedge i_clk) chk(out_en === 1'b0 && global_output_disable === 1'b1, "outputs on");
		@(posedge i_clk) pd_req <= 1'b0;
		wait_in(1'b1);
		chk(global_set_reset === 1'b0 && out_en === 1'b0, "leave order");
		@(negedge i_clk) chk(out_en === 1'b0, "outputs early");
		@(negedge i_clk) chk(out_en === 1'b1 && rst === exp_rst, "leave");
		// Mode, clock and pin outputs follow one edge after the restart
		@(negedge i_clk);
		for (int i = 0; i < 20 && !settled; i++) @(negedge i_clk);
		if (!settled) begin
			chk(0, "board never settled");
			give_verdict();
		end
	endtask : pd_cycle
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (6) @(negedge i_clk);
		chk(in_en === 1'b1 && global_set_reset === 1'b0 && tap === 1'b1, "reset values");
		chk(mpu === 1'b1, "mode pull-ups before configuration");
		foreach (rows[k]) begin
			@(posedge i_clk) mode <= rows[k].pins;
			pd_cycle(1'b1);
			chk(cmode === rows[k].mode && config_clock_oe === rows[k].config_clock, "mode");
			chk(high_during_config.oe === rows[k].high_during_config && low_during_config.oe === rows[k].high_during_config, "cfg pins");
			chk(high_during_config.out === 1'b1 && low_during_config.out === 1'b0, "cfg levels");
			chk(init_pin.oe === 1'b1 && init_pin.out === 1'b0, "init pull");
			@(posedge i_clk) done <= 1'b1;
			@(posedge i_clk) done <= 1'b0;
			repeat (2) @(negedge i_clk);
			chk(high_during_config.oe === 1'b0 && config_clock_oe === 1'b0 && init_pin.oe === 1'b0, "user io");
			chk(mpu === 1'b0, "mode pull-ups after configuration");
			if (k < 3) begin
				@(posedge i_clk) prog_n <= 1'b0;
				repeat (6) @(posedge i_clk);
				prog_n <= 1'b1;
				repeat (6) @(posedge i_clk);
			end
		end
		// Configured: mode pins ignored and no restart
		// Pins now ask for slave serial; the stored express mode must stay
		@(posedge i_clk) mode <= 2'h3;
		pd_cycle(1'b0);
		chk(cmode === 2'h2, "mode resampled");
		rd_reg(4'h4);
		chk(rdv[4] === 1'b1 && rdv[1:0] === 2'h0, "status");
		@(posedge i_clk) wr <= 1'b1;
		addr <= 4'h0;
		wdata <= 32'h3;
		@(posedge i_clk) wr <= 1'b0;
		repeat (2) @(negedge i_clk);
		chk(global_set_reset === 1'b1 && global_output_disable === 1'b1, "sw reset");
		@(posedge i_clk) extest <= 1'b1;
		repeat (2) @(negedge i_clk);
		chk(global_output_disable === 1'b0, "output-disable during external test");
		@(posedge i_clk) extest <= 1'b0;
		rd_reg(4'hC);
		chk(rdv === 32'h0, "unmapped read");
		@(posedge i_clk) prog_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		prog_n <= 1'b1;
		rd_reg(4'h4);
		chk(rdv[4] === 1'b0, "program ignored");
		give_verdict();
	end
endmodule : tb_pdc_power_down_ctrl
